// ==== mon_ctrl.sv ====
// Register file, interrupt pin and reading storage of the eight-channel monitor.
`include "mon_map.svh"
module mon_ctrl #(
  parameter int VoltCyc = `MON_VOLT_CONV_US * 1000 / `MON_CLK_PERIOD_NS, // voltage conversion
  parameter int TempCyc = `MON_TEMP_CONV_US * 1000 / `MON_CLK_PERIOD_NS, // temperature conversion
  parameter int LpPassCyc = `MON_LP_PASS_MS * 1000000 / `MON_CLK_PERIOD_NS, // low-power pass
  parameter int WarmCyc = `MON_WARMUP_MS * 1000000 / `MON_CLK_PERIOD_NS, // start-up warmup
  parameter logic [7:0] MakerCode = 8'h5a, // Arbitrary value.
  parameter logic [7:0] RevCode = 8'h3c // Arbitrary value.
) (
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] regAddr, // register address from the serial target
  input wire logic [7:0] regWrData, // write data byte
  input wire logic regWrEn, // one-cycle write strobe
  input wire logic regRdEn, // one-cycle read strobe
  input wire logic busActive, // serial transaction in progress
  output logic [15:0] regRdData, // read data, valid the cycle after the strobe
  input wire mon_pkg::mon_sample_t convData, // front-end result at conversion end
  output logic convStart, // one-cycle start of a conversion
  output mon_pkg::mon_chan_t convChan, // channel being converted
  output logic analogSleep, // deep sleep request to the front end
  output logic intPinOut, // open-drain interrupt level, always low
  output logic intPinOe // high while the interrupt pin is pulled low
);
  logic [7:0] cfg_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] rate_r;
  logic [7:0] chanOff_r;
  logic [7:0] deep_r;
  logic [7:0] advCfg_r;
  logic warmPending_r;
  logic [23:0] warmCnt_r;
  logic [15:0] regRdData_r;
  logic intPinOe_r;
  logic intPinOut_r;
  logic analogSleep_r;
  logic [15:0] reading_r [8];
  logic [7:0] limit_r [16];
  logic [7:0] cfg_nxt;
  logic [7:0] status_nxt;
  logic fault;

  mon_seq_if seqBus ();

  mon_sequencer #(
    .VoltCyc(VoltCyc),
    .TempCyc(TempCyc),
    .LpPassCyc(LpPassCyc)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .sb(seqBus.seq)
  );

  // Address decode.
  wire logic wrCfg = regWrEn && (regAddr == `MON_ADDR_CFG);
  wire logic wrMask = regWrEn && (regAddr == `MON_ADDR_MASK);
  wire logic wrRate = regWrEn && (regAddr == `MON_ADDR_RATE);
  wire logic wrChOff = regWrEn && (regAddr == `MON_ADDR_CHOFF);
  wire logic wrOneShot = regWrEn && (regAddr == `MON_ADDR_ONESHOT);
  wire logic wrDeep = regWrEn && (regAddr == `MON_ADDR_DEEP);
  wire logic wrAdv = regWrEn && (regAddr == `MON_ADDR_ADVCFG);
  wire logic inRead = (regAddr >= `MON_ADDR_READ_LO) && (regAddr <= `MON_ADDR_READ_HI);
  wire logic inLim = (regAddr >= `MON_ADDR_LIM_LO) && (regAddr <= `MON_ADDR_LIM_HI);
  wire logic wrLim = regWrEn && inLim;
  wire logic rdStatus = regRdEn && (regAddr == `MON_ADDR_STATUS);
  wire logic softDef = wrCfg && regWrData[`MON_CFG_SOFTDEF];
  wire logic [2:0] readIdx = regAddr[2:0];
  wire logic [3:0] limIdx = 4'(regAddr - `MON_ADDR_LIM_LO);

  // Control bits as the loop sees them.
  wire logic startBit = cfg_r[`MON_CFG_START];
  wire logic intEnBit = cfg_r[`MON_CFG_INTEN];
  wire logic releaseBit = cfg_r[`MON_CFG_RELEASE];

  // The loop runs only with start set and release clear, so clearing release resumes it.
  assign seqBus.run = startBit && !releaseBit;
  // A one-shot write only counts while start is clear; the data byte is dropped.
  assign seqBus.oneShot = wrOneShot && !startBit;
  assign seqBus.lowPower = !rate_r[`MON_RATE_CONT];
  assign seqBus.holdOff = busActive;
  assign seqBus.chanOff = chanOff_r;
  assign seqBus.convData = convData;

  // Comparison of the finished reading against its limit pair.
  wire logic [3:0] hiIdx = {seqBus.resultChan, 1'b0};
  wire logic [3:0] loIdx = {seqBus.resultChan, 1'b1};

  mon_limit_cmp u_cmp (
    .chan(seqBus.resultChan),
    .data(seqBus.resultData),
    .limHi(limit_r[hiIdx]),
    .limLo(limit_r[loIdx]),
    .fault(fault)
  );

  // While release is set the status register can only be cleared, so a late result is not flagged.
  wire logic commit = seqBus.resultValid;
  wire logic [7:0] chanBit = 8'h01 << seqBus.resultChan;
  wire logic [7:0] statusSet = (commit && fault && !releaseBit) ? chanBit : 8'h00;
  wire logic statusClr = rdStatus || softDef;
  wire logic unmaskedFault = |(status_r & ~mask_r);
  wire logic intOe_nxt = intEnBit && !releaseBit && unmaskedFault;

  always_comb begin
    status_nxt = (statusClr ? `MON_ZERO_RESET : status_r) | statusSet;
    cfg_nxt = cfg_r;
    if (softDef) begin
      cfg_nxt = `MON_CFG_RESET;
    end else if (wrCfg) begin
      cfg_nxt = regWrData & `MON_CFG_WMASK;
    end
  end

  // Read multiplexer; unmapped and write-only addresses return zero.
  wire logic [15:0] rdMux =
    inRead ? reading_r[readIdx] :
    inLim ? {8'h00, limit_r[limIdx]} :
    (regAddr == `MON_ADDR_CFG) ? {8'h00, cfg_r} :
    (regAddr == `MON_ADDR_STATUS) ? {8'h00, status_r} :
    (regAddr == `MON_ADDR_MASK) ? {8'h00, mask_r} :
    (regAddr == `MON_ADDR_RATE) ? {8'h00, rate_r} :
    (regAddr == `MON_ADDR_CHOFF) ? {8'h00, chanOff_r} :
    (regAddr == `MON_ADDR_DEEP) ? {8'h00, deep_r} :
    (regAddr == `MON_ADDR_ADVCFG) ? {8'h00, advCfg_r} :
    (regAddr == `MON_ADDR_BUSY) ? {14'h0000, warmPending_r, seqBus.busy} :
    (regAddr == `MON_ADDR_MAKER) ? {8'h00, MakerCode} :
    (regAddr == `MON_ADDR_REV) ? {8'h00, RevCode} :
    16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= `MON_CFG_RESET;
      status_r <= `MON_ZERO_RESET;
    end else begin
      cfg_r <= cfg_nxt;
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= `MON_ZERO_RESET;
      rate_r <= `MON_ZERO_RESET;
      chanOff_r <= `MON_ZERO_RESET;
      advCfg_r <= `MON_ZERO_RESET;
    end else if (softDef) begin
      mask_r <= `MON_ZERO_RESET;
      rate_r <= `MON_ZERO_RESET;
      chanOff_r <= `MON_ZERO_RESET;
      advCfg_r <= `MON_ZERO_RESET;
    end else begin
      mask_r <= wrMask ? regWrData : mask_r;
      rate_r <= wrRate ? (regWrData & `MON_RATE_WMASK) : rate_r;
      chanOff_r <= wrChOff ? regWrData : chanOff_r;
      advCfg_r <= wrAdv ? (regWrData & `MON_ADV_WMASK) : advCfg_r;
    end
  end

  // Deep sleep is only a request to the front end; the loop is already stopped by then.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deep_r <= `MON_ZERO_RESET;
      analogSleep_r <= 1'b0;
    end else begin
      deep_r <= softDef ? `MON_ZERO_RESET : (wrDeep ? (regWrData & `MON_DEEP_WMASK) : deep_r);
      analogSleep_r <= deep_r[`MON_DEEP_BIT] && !seqBus.busy;
    end
  end

  // Warmup flag stays set for the start-up time after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warmCnt_r <= 24'h000000;
      warmPending_r <= 1'b1;
    end else begin
      warmCnt_r <= warmPending_r ? warmCnt_r + 24'h000001 : warmCnt_r;
      warmPending_r <= warmPending_r && (warmCnt_r < 24'(WarmCyc - 1));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData_r <= 16'h0000;
      intPinOe_r <= 1'b0;
      intPinOut_r <= 1'b0;
    end else begin
      regRdData_r <= regRdEn ? rdMux : regRdData_r;
      intPinOe_r <= intOe_nxt;
      intPinOut_r <= 1'b0;
    end
  end

  // Readings and limits have no reset, so they read undefined until written.
  always_ff @(posedge clk) begin
    if (commit) begin
      reading_r[seqBus.resultChan] <= {4'h0, seqBus.resultData};
    end
    if (wrLim) begin
      limit_r[limIdx] <= regWrData;
    end
  end

  assign regRdData = regRdData_r;
  assign convStart = seqBus.convStart;
  assign convChan = seqBus.convChan;
  assign analogSleep = analogSleep_r;
  assign intPinOut = intPinOut_r;
  assign intPinOe = intPinOe_r;

  default clocking ctrlCb @(posedge clk); endclocking
  default disable iff (rst);

  soft_restore_a: assert property ((softDef && statusSet == 8'h00) |=>
      (cfg_r == 8'h08 && mask_r == 8'h00 && rate_r == 8'h00 && status_r == 8'h00))
    else $error("soft defaults did not restore the registers");
  int_gate_a: assert property (intPinOe |-> $past(intEnBit) && !$past(releaseBit))
    else $error("interrupt asserted without enable or with release set");
  release_quiet_a: assert property (releaseBit |=> !intPinOe)
    else $error("interrupt asserted while release is set");
  release_hold_a: assert property ((releaseBit && !statusClr) |=> $stable(status_r))
    else $error("status changed while release is set");
  mask_block_a: assert property (intPinOe |-> $past(unmaskedFault))
    else $error("interrupt asserted with only masked faults");
  stop_keeps_a: assert property ((wrCfg && regWrData == 8'h02 && unmaskedFault && !rdStatus
      ##1 !regRdEn && !regWrEn) |=> intPinOe)
    else $error("clearing start released the interrupt");
  status_clr_a: assert property ((rdStatus && statusSet == 8'h00) |=> status_r == 8'h00
      ##1 !intPinOe)
    else $error("status read did not clear status and interrupt");
  fault_set_a: assert property ((statusSet != 8'h00) |=>
      ((status_r & $past(statusSet)) == $past(statusSet)))
    else $error("fault did not set its status bit");
  reading_upd_a: assert property (commit |=>
      reading_r[$past(seqBus.resultChan)] == {4'h0, $past(seqBus.resultData)})
    else $error("reading register not updated with the finished result");
  oneshot_zero_a: assert property ((regRdEn && regAddr == 8'h09) |=> regRdData == 16'h0000)
    else $error("one-shot address read returned nonzero");

  // The loop only starts from idle, so an idle sequencer shows whether it may start.
  stop_quiet_a: assert property (
      (!seqBus.run && !seqBus.busy && !wrOneShot) |=> !convStart)
    else $error("conversion started while stopped");

  release_halt_a: assert property (
      (releaseBit && !seqBus.busy && !wrOneShot) |=> !convStart)
    else $error("conversion started while release is set");

  resume_loop_a: assert property (
      (startBit && !releaseBit && !seqBus.busy && chanOff_r != 8'hff) |=> convStart)
    else $error("loop did not resume");

  int_follow_a: assert property (
      (intEnBit && !releaseBit && unmaskedFault) |=> intPinOe)
    else $error("interrupt not asserted for an unmasked fault");

  mask_quiet_a: assert property (
      !unmaskedFault |=> !intPinOe)
    else $error("interrupt asserted without an unmasked fault");

  enable_quiet_a: assert property (
      !intEnBit |=> !intPinOe)
    else $error("interrupt asserted while disabled");

  status_read_a: assert property (
      rdStatus |=> regRdData == {8'h00, $past(status_r)})
    else $error("status read returned wrong contents");

  cfg_read_a: assert property (
      (regRdEn && regAddr == 8'h00) |=> regRdData == {8'h00, $past(cfg_r)})
    else $error("configuration read returned wrong contents");

  maker_read_a: assert property (
      (regRdEn && regAddr == 8'h3e) |=> regRdData == {8'h00, MakerCode})
    else $error("maker identity read wrong");

  rev_read_a: assert property (
      (regRdEn && regAddr == 8'h3f) |=> regRdData == {8'h00, RevCode})
    else $error("revision identity read wrong");

  read_stand_a: assert property (
      !regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");

  oneshot_drop_a: assert property (
      wrOneShot |=> $stable(cfg_r) && $stable(mask_r) && $stable(rate_r) && $stable(deep_r))
    else $error("one-shot data was stored");

  deep_sleep_a: assert property (
      (deep_r[`MON_DEEP_BIT] && !seqBus.busy) |=> analogSleep)
    else $error("deep sleep not requested while idle");

  deep_wake_a: assert property (
      !deep_r[`MON_DEEP_BIT] |=> !analogSleep)
    else $error("deep sleep requested while bit clear");

  warm_done_a: assert property (
      !warmPending_r |=> !warmPending_r)
    else $error("warmup flag set again");

  status_keep_a: assert property (
      (!statusClr && statusSet == 8'h00) |=> $stable(status_r))
    else $error("status changed without set or clear");

  rate_store_a: assert property (
      wrRate |=> rate_r == ($past(regWrData) & 8'h01))
    else $error("rate write not stored");

  mask_store_a: assert property (
      wrMask |=> mask_r == $past(regWrData))
    else $error("mask write not stored");

  deep_store_a: assert property (
      wrDeep |=> deep_r == ($past(regWrData) & 8'h01))
    else $error("deep sleep write not stored");

  busy_read_a: assert property (
      (regRdEn && regAddr == 8'h0c) |=> regRdData == {14'h0000, $past(warmPending_r), $past(seqBus.busy)})
    else $error("busy read returned wrong flags");

  cfg_store_a: assert property (
      (wrCfg && !softDef) |=> cfg_r == ($past(regWrData) & 8'h0b))
    else $error("configuration write stored wrong bits");
endmodule : mon_ctrl

// ==== mon_map.svh ====
// Register offsets, field positions, reset values and timing figures of the monitor.
`ifndef MON_MAP_SVH
`define MON_MAP_SVH
`define MON_ADDR_CFG 8'h00
`define MON_ADDR_STATUS 8'h01
`define MON_ADDR_MASK 8'h03
`define MON_ADDR_RATE 8'h07
`define MON_ADDR_CHOFF 8'h08
`define MON_ADDR_ONESHOT 8'h09
`define MON_ADDR_DEEP 8'h0a
`define MON_ADDR_ADVCFG 8'h0b
`define MON_ADDR_BUSY 8'h0c
`define MON_ADDR_READ_LO 8'h20
`define MON_ADDR_READ_HI 8'h27
`define MON_ADDR_LIM_LO 8'h2a
`define MON_ADDR_LIM_HI 8'h39
`define MON_ADDR_MAKER 8'h3e
`define MON_ADDR_REV 8'h3f
`define MON_CFG_START 0
`define MON_CFG_INTEN 1
`define MON_CFG_RELEASE 3
`define MON_CFG_SOFTDEF 7
`define MON_CFG_WMASK 8'h0b
`define MON_RATE_CONT 0
`define MON_RATE_WMASK 8'h01
`define MON_DEEP_BIT 0
`define MON_DEEP_WMASK 8'h01
`define MON_ADV_WMASK 8'h07
`define MON_BUSY_BIT 0
`define MON_WARM_BIT 1
`define MON_CFG_RESET 8'h08
`define MON_ZERO_RESET 8'h00
`define MON_TEMP_CHAN 3'h7
`define MON_CLK_PERIOD_NS 100
`define MON_VOLT_CONV_US 12200
`define MON_TEMP_CONV_US 3600
`define MON_LP_PASS_MS 728
`define MON_WARMUP_MS 33
`endif

// ==== mon_pkg.sv ====
// Types shared by the monitor control modules.
package mon_pkg;
  typedef enum logic [1:0] {
    MON_IDLE = 2'b00,
    MON_CONV = 2'b01,
    MON_HOLD = 2'b11,
    MON_LPWAIT = 2'b10
  } mon_seq_state_t;
  typedef logic [2:0] mon_chan_t;
  typedef logic [11:0] mon_sample_t;
endpackage : mon_pkg

// ==== mon_seq_if.sv ====
// Signals between the register file and the conversion sequencer.
interface mon_seq_if;
  logic run;
  logic oneShot;
  logic lowPower;
  logic holdOff;
  logic [7:0] chanOff;
  mon_pkg::mon_sample_t convData;
  logic resultValid;
  mon_pkg::mon_chan_t resultChan;
  mon_pkg::mon_sample_t resultData;
  logic convStart;
  mon_pkg::mon_chan_t convChan;
  logic busy;
  modport ctrl (output run, oneShot, lowPower, holdOff, chanOff, convData,
                input resultValid, resultChan, resultData, convStart, convChan, busy);
  modport seq (input run, oneShot, lowPower, holdOff, chanOff, convData,
               output resultValid, resultChan, resultData, convStart, convChan, busy);
endinterface : mon_seq_if

// ==== mon_limit_cmp.sv ====
// Window comparison of one finished voltage reading against its limits; temperature is checked against its high limit only.
`include "mon_map.svh"
module mon_limit_cmp (
  input wire mon_pkg::mon_chan_t chan, // channel of the reading
  input wire mon_pkg::mon_sample_t data, // finished reading
  input wire logic [7:0] limHi, // high limit byte
  input wire logic [7:0] limLo, // low limit byte
  output logic fault // voltage reading outside its window, or temperature above its high limit
);
  // Voltage limits cover the upper eight bits; temperature is half-degree signed.
  wire logic isTemp = (chan == `MON_TEMP_CHAN);
  wire logic voltFault = (data[11:4] > limHi) || (data[11:4] <= limLo);
  wire logic tempFault = $signed(data[8:1]) > $signed(limHi);
  assign fault = isTemp ? tempFault : voltFault;
endmodule : mon_limit_cmp

// ==== mon_sequencer.sv ====
// Round-robin conversion sequencer with continuous, low-power and one-shot passes.
`include "mon_map.svh"
module mon_sequencer #(
  parameter int VoltCyc = 122000, // cycles per voltage conversion
  parameter int TempCyc = 36000, // cycles per temperature conversion
  parameter int LpPassCyc = 7280000 // cycles per low-power pass
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  mon_seq_if.seq sb // link to the register file
);
  mon_pkg::mon_seq_state_t state_r;
  mon_pkg::mon_seq_state_t state_nxt;
  logic [23:0] convCnt_r;
  logic [23:0] passCnt_r;
  mon_pkg::mon_chan_t chan_r;
  mon_pkg::mon_chan_t chan_nxt;
  logic single_r;
  logic convStart_r;
  logic resultValid_r;
  mon_pkg::mon_chan_t resultChan_r;
  mon_pkg::mon_sample_t resultData_r;
  logic busy_r;

  // Returns {found, index} of the first enabled channel at or after a start point.
  function automatic logic [3:0] nextOn(input logic [7:0] off, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (i >= int'(from) && !off[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : nextOn

  wire logic [3:0] firstOn = nextOn(sb.chanOff, 4'h0);
  wire logic [3:0] nextAfter = nextOn(sb.chanOff, {1'b0, chan_r} + 4'h1);
  wire logic goPass = (sb.run || sb.oneShot) && firstOn[3];
  wire logic [23:0] convLast = (chan_r == `MON_TEMP_CHAN) ? 24'(TempCyc - 1) : 24'(VoltCyc - 1);
  wire logic convEnd = (convCnt_r == convLast);
  wire logic passEnd = !nextAfter[3];
  wire logic lpDone = (passCnt_r >= 24'(LpPassCyc - 1));
  wire logic commitNow = (state_r == mon_pkg::MON_HOLD) && !sb.holdOff;
  wire logic startConv = (state_nxt == mon_pkg::MON_CONV) && (state_r != mon_pkg::MON_CONV);
  wire logic passStart = startConv && (state_r != mon_pkg::MON_HOLD || passEnd);

  always_comb begin
    state_nxt = state_r;
    chan_nxt = firstOn[2:0];
    unique case (state_r)
      mon_pkg::MON_IDLE: begin
        if (goPass) begin
          state_nxt = mon_pkg::MON_CONV;
        end
      end
      mon_pkg::MON_CONV: begin
        if (convEnd) begin
          state_nxt = mon_pkg::MON_HOLD;
        end
      end
      mon_pkg::MON_HOLD: begin
        if (sb.holdOff) begin
          state_nxt = mon_pkg::MON_HOLD;
        end else if (!sb.run && !single_r) begin
          state_nxt = mon_pkg::MON_IDLE;
        end else if (!passEnd) begin
          state_nxt = mon_pkg::MON_CONV;
          chan_nxt = nextAfter[2:0];
        end else if (single_r || !firstOn[3]) begin
          state_nxt = mon_pkg::MON_IDLE;
        end else if (sb.lowPower) begin
          state_nxt = mon_pkg::MON_LPWAIT;
        end else begin
          state_nxt = mon_pkg::MON_CONV;
        end
      end
      mon_pkg::MON_LPWAIT: begin
        if (!sb.run) begin
          state_nxt = mon_pkg::MON_IDLE;
        end else if (lpDone && firstOn[3]) begin
          state_nxt = mon_pkg::MON_CONV;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= mon_pkg::MON_IDLE;
      convCnt_r <= 24'h000000;
      passCnt_r <= 24'h000000;
      chan_r <= 3'h0;
      single_r <= 1'b0;
      convStart_r <= 1'b0;
      resultValid_r <= 1'b0;
      resultChan_r <= 3'h0;
      resultData_r <= 12'h000;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      convCnt_r <= startConv ? 24'h000000 : convCnt_r + 24'h000001;
      passCnt_r <= passStart ? 24'h000000 : passCnt_r + 24'h000001;
      chan_r <= startConv ? chan_nxt : chan_r;
      single_r <= (state_r == mon_pkg::MON_IDLE && goPass) ? !sb.run : single_r;
      convStart_r <= startConv;
      resultValid_r <= commitNow;
      // The channel counter moves on at the commit edge, so the committed channel is kept apart.
      resultChan_r <= commitNow ? chan_r : resultChan_r;
      resultData_r <= (state_r == mon_pkg::MON_CONV && convEnd) ? sb.convData : resultData_r;
      busy_r <= (state_nxt != mon_pkg::MON_IDLE);
    end
  end

  assign sb.convStart = convStart_r;
  assign sb.convChan = chan_r;
  assign sb.resultValid = resultValid_r;
  assign sb.resultChan = resultChan_r;
  assign sb.resultData = resultData_r;
  assign sb.busy = busy_r;

  default clocking seqCb @(posedge clk); endclocking
  default disable iff (rst);

  hold_off_a: assert property (sb.resultValid |-> !$past(sb.holdOff))
    else $error("reading committed while a bus transaction was active");
  stop_idle_a: assert property ((state_r == mon_pkg::MON_IDLE && !sb.run && !sb.oneShot)
      |=> state_r == mon_pkg::MON_IDLE)
    else $error("sequencer left idle while stopped");
  one_shot_go_a: assert property ((state_r == mon_pkg::MON_IDLE && sb.oneShot && firstOn[3])
      |=> state_r == mon_pkg::MON_CONV && sb.convStart)
    else $error("one-shot write did not start a conversion");
endmodule : mon_sequencer

// ==== mon_front_model.sv ====
// Behavioural analog front end that answers each conversion with a fixed level per channel.
module mon_front_model (
  input wire mon_pkg::mon_chan_t convChan, // channel being converted
  input wire logic [3:0] bias, // offset the bench adds to every level
  output mon_pkg::mon_sample_t convData // level presented for the current channel
);
  // The level follows the channel, so a stale channel number shows up as a wrong reading.
  assign convData = (convChan == 3'h7) ? 12'h032 + 12'(bias)
                                       : {1'b0, convChan, 8'h80} + 12'(bias);
endmodule : mon_front_model

// ==== testbench.sv ====
// Self-checking testbench of the monitor control block.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int VoltC = 20;
  localparam int TempC = 10;
  localparam logic [7:0] Lim [16] = '{8'h05, 8'h00, 8'h05, 8'h00, 8'hff, 8'h00, 8'hff, 8'h38,
                                      8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h19, 8'h00};
  localparam logic [2:0] Ord [8] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  localparam logic [7:0] Zr [5] = '{8'h01, 8'h03, 8'h07, 8'h0a, 8'h0b};
  logic clk, rst, regWrEn, regRdEn, busActive;
  logic [7:0] regAddr, regWrData;
  logic [15:0] regRdData, rdVal;
  logic [3:0] bias;
  logic convStart, analogSleep, intPinOut, intPinOe;
  mon_pkg::mon_chan_t convChan;
  mon_pkg::mon_sample_t convData;
  // The pull-up holds the line high whenever the block releases it.
  wire intLineN = intPinOe ? intPinOut : 1'b1;
  int err_count, checks, starts, cyc, s;
  mon_pkg::mon_chan_t chanQ[$];
  int stampQ[$];

  mon_ctrl #(.VoltCyc(VoltC), .TempCyc(TempC), .LpPassCyc(400), .WarmCyc(16),
    .MakerCode(8'h6b), .RevCode(8'h2d)) i_mon_ctrl (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .busActive(busActive), .regRdData(regRdData), .convData(convData),
    .convStart(convStart), .convChan(convChan), .analogSleep(analogSleep),
    .intPinOut(intPinOut), .intPinOe(intPinOe));
  mon_front_model i_mon_front_model (.convChan(convChan), .bias(bias), .convData(convData));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (convStart === 1'b1) begin
      starts <= starts + 1;
      chanQ.push_back(convChan);
      stampQ.push_back(cyc);
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chkPin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chkPin

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 rdVal = regRdData;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    rd(a);
    chk16(rdVal, exp);
  endtask : rdc

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitCyc

  task automatic wrap_up();
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // The whole sequence needs about 2100 cycles; the limit leaves ample margin.
  initial begin
    #(20000 * 100);
    err_count++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    busActive = 1'b0;
    bias = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h0c, 16'h0002);
    rdc(8'h00, 16'h0008);
    foreach (Zr[i]) rdc(Zr[i], 16'h0000);
    wr(8'h3e, 8'h00);
    rdc(8'h3e, 16'h006b);
    rdc(8'h3f, 16'h002d);
    rdc(8'h3c, 16'h0000);
    rd(8'h0c);
    for (int i = 0; i < 40 && rdVal[1] !== 1'b0; i++) rd(8'h0c);
    chk16(rdVal, 16'h0000);
    wr(8'h0b, 8'h00);
    wr(8'h07, 8'h01);
    wr(8'h08, 8'h04);
    wr(8'h03, 8'h02);
    for (int i = 0; i < 16; i++) wr(8'h2a + 8'(i), Lim[i]);
    wr(8'h00, 8'h01);
    waitCyc(200);
    chkPin(intLineN, 1'b1);
    for (int i = 0; i < 8; i++) chk16(16'(chanQ[i]), 16'(Ord[i]));
    chk16(16'(stampQ[7] - 2 * stampQ[6] + stampQ[5]), 16'(TempC - VoltC));
    rdc(8'h01, 16'h000b);
    rdc(8'h20, 16'h0080);
    rdc(8'h23, 16'h0380);
    rdc(8'h27, 16'h0032);
    wr(8'h00, 8'h03);
    waitCyc(200);
    chkPin(intLineN, 1'b0);
    wr(8'h03, 8'hff);
    waitCyc(2);
    chkPin(intLineN, 1'b1);
    wr(8'h03, 8'h02);
    waitCyc(2);
    chkPin(intLineN, 1'b0);
    wr(8'h00, 8'h02);
    waitCyc(50);
    chkPin(intLineN, 1'b0);
    s = starts;
    waitCyc(100);
    chk16(16'(starts - s), 16'h0000);
    rdc(8'h07, 16'h0001);
    rdc(8'h01, 16'h000b);
    @(posedge clk);
    #1 chkPin(intLineN, 1'b1);
    s = starts;
    wr(8'h00, 8'h03);
    waitCyc(5);
    chk16(16'(starts > s), 16'h0001);
    waitCyc(200);
    wr(8'h00, 8'h0b);
    waitCyc(2);
    chkPin(intLineN, 1'b1);
    waitCyc(50);
    s = starts;
    waitCyc(100);
    chk16(16'(starts - s), 16'h0000);
    rdc(8'h01, 16'h000b);
    wr(8'h00, 8'h00);
    wr(8'h07, 8'h00);
    waitCyc(50);
    s = starts;
    wr(8'h00, 8'h01);
    waitCyc(380);
    chk16(16'(starts - s), 16'h0007);
    wr(8'h00, 8'h00);
    waitCyc(50);
    wr(8'h0a, 8'h01);
    s = starts;
    wr(8'h09, 8'ha5);
    waitCyc(250);
    chk16(16'(starts - s), 16'h0007);
    rdc(8'h0a, 16'h0001);
    chkPin(analogSleep, 1'b1);
    rdc(8'h09, 16'h0000);
    wr(8'h0a, 8'h00);
    @(posedge clk);
    bias <= 4'h1;
    busActive <= 1'b1;
    wr(8'h09, 8'h00);
    waitCyc(100);
    rdc(8'h20, 16'h0080);
    @(posedge clk);
    busActive <= 1'b0;
    waitCyc(250);
    rdc(8'h20, 16'h0081);
    chkPin(analogSleep, 1'b0);
    wr(8'h07, 8'h01);
    wr(8'h00, 8'h80);
    rdc(8'h00, 16'h0008);
    rdc(8'h03, 16'h0000);
    rdc(8'h07, 16'h0000);
    rdc(8'h20, 16'h0081);
    rdc(8'h2a, 16'h0005);
    wrap_up();
  end
endmodule : testbench
